// ### bench/ram_checker.sv
`timescale 1ns/1ps
// Output hold, power-up clear and APB answer timing
module ram_checker (
   input wire clk, rst_n, a_ce, a_re, b_ce, b_re, psel, penable, pready, pslverr,
   input wire [31:0] a_q, b_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_acc; psel && penable && !pready; endsequence
   sequence s_up; $rose(rst_n); endsequence
   property p_hold_a; !(a_ce && a_re) |=> $stable(a_q); endproperty
   a_hold_a: assert property (p_hold_a) else $error("a_q moved");
   property p_hold_b; !(b_ce && b_re) |=> $stable(b_q); endproperty
   a_hold_b: assert property (p_hold_b) else $error("b_q moved");
   property p_pwr; s_up |-> a_q == 32'h0 && b_q == 32'h0; endproperty
   a_pwr: assert property (p_pwr) else $error("q not clear");
   property p_clr_a; s_up ##0 !(a_ce && a_re) |=> a_q == 32'h0; endproperty
   a_clr_a: assert property (p_clr_a) else $error("a_q early");
   property p_clr_b; s_up ##0 !(b_ce && b_re) |=> b_q == 32'h0; endproperty
   a_clr_b: assert property (p_clr_b) else $error("b_q early");
   property p_wait; s_acc |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("pready late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready long");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("stray pslverr");
endmodule // ram_checker
bind embedded_ram_block ram_checker chk_u (.clk, .rst_n, .a_ce, .a_re, .b_ce, .b_re, .psel, .penable,
   .pready, .pslverr, .a_q, .b_q);

// ### bench/ram_user_b.sv
`timescale 1ns/1ps
// Port B user logic reads only, so port A stays predictable
module ram_user_b (
   input wire clk,
   output logic b_ce = 0, b_we = 0, b_re = 0,
   output logic [7:0] b_addr = 0,
   output logic [31:0] b_wdata = 0,
   output logic [3:0] b_be = 0
);
   // Read enable raised and dropped at random on every clock
   always @(posedge clk) begin
      {b_ce, b_re, b_be, b_wdata} <= 38'({$urandom, $urandom});
      b_addr <= 8'($urandom % 4); // Same few words as port A, so mixed-port collisions occur
   end
endmodule // ram_user_b

// ### bench/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module tb;
   localparam logic [31:0] INIT = 32'h5a5a_0f0f;
   logic clk = 0, rst_n = 0, a_ce = 0, a_we = 0, a_re = 0, psel = 0, penable = 0, pwrite = 0, err, b_hit;
   logic [2:0] mode = 0;
   logic [3:0] a_be = 0;
   logic [7:0] a_addr = 0;
   logic [11:0] paddr = 0;
   logic [31:0] a_wdata = 0, pwdata = 0, exp_q = 0, exp_b = 0, rd, old, old_b, mem [256];
   wire [31:0] a_q, b_q, prdata, b_wdata;
   wire [7:0] b_addr;
   wire [3:0] b_be;
   wire b_ce, b_we, b_re, pready, pslverr;
   int err_total = 0, num_checks = 0;
   embedded_ram_block #(.INIT_WORD(INIT)) dut_u (.*);
   ram_user_b user_u (.*);
   initial forever #12.5 clk = ~clk;
   // Enabled lanes take the new byte
   function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] be);
      for (int k = 0; k < 4; k++) if (be[k]) o[8*k +: 8] = n[8*k +: 8];
      return o;
   endfunction
   task automatic tally_and_finish;
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk) penable <= 1;
      for (n = 0; n < 20 && pready !== 1; n++) @(posedge clk);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b0;
      if (n == 20) begin
         err_total++;
         tally_and_finish;
      end
      @(posedge clk);
   endtask
   // Model the word at the edge, then look at the output
   task automatic step;
      @(posedge clk);
      old = mem[a_addr];
      old_b = mem[b_addr];
      b_hit = b_ce && b_re;
      if (b_hit) exp_b = (a_ce && a_we && a_addr == b_addr && mode[2]) ? merge(old_b, a_wdata, a_be) : old_b;
      if (a_ce && a_we) mem[a_addr] = merge(old, a_wdata, a_be);
      if (a_ce && a_re) exp_q = (a_we && !mode[0]) ? mem[a_addr] : old;
      #1 `CHK(a_q, exp_q)
      if (b_hit) `CHK(b_q, exp_b)
   endtask
   initial begin
      void'($urandom(83522));
      foreach (mem[i]) mem[i] = INIT;
      repeat (6) @(posedge clk);
      rst_n <= 1;
      repeat (3) step;
      {a_ce, a_re, a_addr} <= {2'b11, 8'h03};
      step;
      a_ce <= 0;
      apb(1, 12'h008, 32'h0000_0003);
      apb(1, 12'h00c, 32'hc0de_0001);
      mem[3] = 32'hc0de_0001;
      apb(0, 12'h00c, 0);
      `CHK(rd, INIT)
      apb(0, 12'h010, 0);
      `CHK({err, rd}, {1'b1, 32'h0})
      // Every mode mix, random traffic on a few words
      for (int m = 0; m < 8; m++) begin
         apb(1, 12'h000, m);
         apb(0, 12'h000, 0);
         `CHK(rd, 32'(m))
         mode = 3'(m);
         repeat (80) begin
            {a_ce, a_we, a_re, a_be} <= 7'($urandom);
            a_addr <= 8'($urandom % 4);
            a_wdata <= $urandom;
            step;
         end
         a_ce <= 0;
      end
      tally_and_finish;
   end
endmodule // tb

// ### core/embedded_ram_block.v
`timescale 1ns/1ps
`include "embedded_ram_defines.vh"

// Function
// - Each port picks one of exactly two same-port read-during-write behaviours.
// - In write-through mode a write with read enable high puts the word written on that port's output at the edge of the write itself.
// - In read-before-write mode a write-and-read shows the word stored before the write.
// - In write-through mode each enabled byte lane is written and also passed to the output.
// - In write-through mode each disabled byte lane is left unchanged in memory and the stored byte is output.
// - Mixed-port handling covers one port reading while the other writes the same address on the same clock.
// - The read outputs are zero after power-up.
// - Preloaded contents show only after the first read following power-up.
// - The memory contents can be preloaded at configuration time.
// - Each port has its own clock enable and does nothing while it is low.
// - A read happens only while read enable is high; user logic keeps it low when not needed.
module embedded_ram_block #(
   parameter AW = 8,
   parameter DW = 32,
   parameter [31:0] INIT_WORD = 32'h0000_0000
) (
   input wire clk,
   input wire rst_n,
   // Port A user side
   input wire a_ce,
   input wire a_we,
   input wire a_re,
   input wire [AW-1:0] a_addr,
   input wire [DW-1:0] a_wdata,
   input wire [DW/8-1:0] a_be,
   output reg [DW-1:0] a_q,
   // Port B user side
   input wire b_ce,
   input wire b_we,
   input wire b_re,
   input wire [AW-1:0] b_addr,
   input wire [DW-1:0] b_wdata,
   input wire [DW/8-1:0] b_be,
   output reg [DW-1:0] b_q,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr
);

   localparam BW = DW / 8;
   localparam DEPTH = 1 << AW;

   reg [DW-1:0] mem [0:DEPTH-1];
   reg [31:0] ctrl_reg;
   reg [2:0] status_reg;
   reg [2:0] status_next;
   reg [AW-1:0] load_addr_reg;
   reg [DW-1:0] a_rd_next;
   reg [DW-1:0] b_rd_next;
   reg [31:0] prdata_next;
   reg slverr_next;
   reg a_collide;
   reg b_collide;
   integer i;

   wire a_wr = a_ce & a_we;
   wire b_wr = b_ce & b_we;
   wire a_rd = a_ce & a_re;
   wire b_rd = b_ce & b_re;
   wire apb_take = psel & penable & pready;
   wire apb_wr = apb_take & pwrite;
   wire load_wr = apb_wr & (paddr == `RAM_LOAD_DATA_OFF);

   // Byte-lane merge: enabled lanes take the new byte, others keep the old
   function [DW-1:0] lane_merge;
      input [DW-1:0] old_word;
      input [DW-1:0] new_word;
      input [BW-1:0] lanes;
      integer k;
      begin
         lane_merge = old_word;
         for (k = 0; k < BW; k = k + 1) begin
            if (lanes[k]) begin
               lane_merge[k*8 +: 8] = new_word[k*8 +: 8];
            end
         end
      end
   endfunction

   // Preload image present from configuration; a fill word keeps it file-free
   initial begin
      for (i = 0; i < DEPTH; i = i + 1) begin
         mem[i] = INIT_WORD[DW-1:0];
      end
   end

   // Memory writes; APB preload first, then A, then B so B wins a double write
   always @(posedge clk) begin
      if (load_wr) begin
         mem[load_addr_reg] <= pwdata[DW-1:0];
      end
      if (a_wr) begin
         mem[a_addr] <= lane_merge(mem[a_addr], a_wdata, a_be);
      end
      if (b_wr) begin
         mem[b_addr] <= lane_merge(mem[b_addr], b_wdata, b_be);
      end
   end

   // Port A read word: same-port mode, then mixed-port bypass from B
   always @* begin
      a_rd_next = mem[a_addr];
      if (a_wr && !ctrl_reg[`CTRL_A_OLD_BIT]) begin
         a_rd_next = lane_merge(mem[a_addr], a_wdata, a_be);
      end
      a_collide = b_wr && (b_addr == a_addr) && !a_wr;
      if (a_collide && ctrl_reg[`CTRL_MIXED_NEW_BIT]) begin
         a_rd_next = lane_merge(a_rd_next, b_wdata, b_be);
      end
   end

   // Port B read word, mirror of port A
   always @* begin
      b_rd_next = mem[b_addr];
      if (b_wr && !ctrl_reg[`CTRL_B_OLD_BIT]) begin
         b_rd_next = lane_merge(mem[b_addr], b_wdata, b_be);
      end
      b_collide = a_wr && (a_addr == b_addr) && !b_wr;
      if (b_collide && ctrl_reg[`CTRL_MIXED_NEW_BIT]) begin
         b_rd_next = lane_merge(b_rd_next, a_wdata, a_be);
      end
   end

   // Output registers clear at reset and only load on an enabled read
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_q <= `RAM_OUT_RESET;
         b_q <= `RAM_OUT_RESET;
      end else begin
         if (a_rd) begin
            a_q <= a_rd_next;
         end
         if (b_rd) begin
            b_q <= b_rd_next;
         end
      end
   end

   // Sticky status; a new event in the clearing cycle survives the clear
   always @* begin
      status_next = status_reg;
      if (apb_wr && (paddr == `RAM_STATUS_OFF)) begin
         status_next = status_reg & ~pwdata[2:0];
      end
      if (a_rd) begin
         status_next[`STAT_A_READ_BIT] = 1'b1;
      end
      if (b_rd) begin
         status_next[`STAT_B_READ_BIT] = 1'b1;
      end
      if ((a_collide && a_rd) || (b_collide && b_rd)) begin
         status_next[`STAT_COLLIDE_BIT] = 1'b1;
      end
   end

   // Read data and error answer for the APB access phase
   always @* begin
      prdata_next = 32'h0000_0000;
      slverr_next = 1'b0;
      if (paddr == `RAM_CTRL_OFF) begin
         prdata_next = {29'h0000_0000, ctrl_reg[2:0]};
      end else if (paddr == `RAM_STATUS_OFF) begin
         prdata_next = {29'h0000_0000, status_reg};
      end else if (paddr == `RAM_LOAD_ADDR_OFF) begin
         prdata_next[AW-1:0] = load_addr_reg;
      end else if (paddr == `RAM_LOAD_DATA_OFF) begin
         prdata_next[DW-1:0] = mem[load_addr_reg];
      end else begin
         slverr_next = 1'b1;
      end
   end

   // APB slave with one wait state; writes take effect at the pready edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         ctrl_reg <= `CTRL_RESET;
         status_reg <= 3'h0;
         load_addr_reg <= {AW{1'b0}};
      end else begin
         pready <= psel & penable & ~pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : prdata_next;
            pslverr <= slverr_next;
         end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
         status_reg <= status_next;
         if (apb_wr && (paddr == `RAM_CTRL_OFF)) begin
            ctrl_reg <= {29'h0000_0000, pwdata[2:0]};
         end
         // Load address steps on after each data word for burst preload
         if (apb_wr && (paddr == `RAM_LOAD_ADDR_OFF)) begin
            load_addr_reg <= pwdata[AW-1:0];
         end else if (load_wr) begin
            load_addr_reg <= load_addr_reg + 1'b1;
         end
      end
   end

endmodule // embedded_ram_block

// ### core/embedded_ram_defines.vh
`ifndef EMBEDDED_RAM_DEFINES_VH
`define EMBEDDED_RAM_DEFINES_VH

// Register byte addresses on the APB slave
`define RAM_CTRL_OFF 12'h000
`define RAM_STATUS_OFF 12'h004
`define RAM_LOAD_ADDR_OFF 12'h008
`define RAM_LOAD_DATA_OFF 12'h00C

// Control register fields
`define CTRL_A_OLD_BIT 0
`define CTRL_B_OLD_BIT 1
`define CTRL_MIXED_NEW_BIT 2
`define CTRL_RESET 32'h0000_0000

// Status register fields, write one to clear
`define STAT_A_READ_BIT 0
`define STAT_B_READ_BIT 1
`define STAT_COLLIDE_BIT 2

`define RAM_OUT_RESET 32'h0000_0000

`endif
